// ==== prx_map.vh ====
`ifndef PRX_MAP_VH
`define PRX_MAP_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define PRX_WAIT_TIME_ADDR 8'h83
`define PRX_WAIT_CFG_ADDR 8'h8d
`define PRX_PULSE_CFG_ADDR 8'h8e
`define PRX_GAIN_CFG_ADDR 8'h8f
`define PRX_REV_ADDR 8'h91
`define PRX_PART_ADDR 8'h92
`define PRX_FLAGS_ADDR 8'h93
`define PRX_MISC_CFG_ADDR 8'hab
// ----------------------------------------
// reset values
// ----------------------------------------
`define PRX_WAIT_TIME_RST 8'h00
`define PRX_WAIT_CFG_RST 8'h80
`define PRX_PULSE_CFG_RST 8'h4f
`define PRX_GAIN_CFG_RST 8'h80
`define PRX_MISC_CFG_RST 8'h0c
// ----------------------------------------
// field positions
// ----------------------------------------
`define PRX_WSTRETCH_BIT 2
`define PRX_CLR_ON_READ_BIT 7
`define PRX_F_SAT 6
`define PRX_F_PROX 5
`define PRX_F_CAL 3
`define PRX_F_ZERO 2
`define PRX_F_REFL 1
`define PRX_F_AMB 0
`define PRX_FLAG_MASK 8'h6f
// ----------------------------------------
// timing
// ----------------------------------------
`define PRX_CLK_HZ 10000000
`define PRX_WAIT_STEP_US 2810
`define PRX_WAIT_STEP_CYC ((`PRX_WAIT_STEP_US * (`PRX_CLK_HZ / 1000000)))
`define PRX_STRETCH_MUL 12
`define PRX_PULSE_BASE_US 4
`define PRX_PULSE_BASE_CYC (`PRX_PULSE_BASE_US * (`PRX_CLK_HZ / 1000000))
`define PRX_LED_STEP_MA 6
`endif

// ==== prx_wait_timer.v ====
`timescale 1ns/100ps
`default_nettype none
`include "prx_map.vh"
module prx_wait_timer #(
  parameter STEP_CYC = `PRX_WAIT_STEP_CYC
) (
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire start_i,
  input wire [7:0] wait_val_i,
  input wire stretch_i,
  output reg busy_o,
  output reg done_o
);
  reg [15:0] pre_r;
  reg [3:0] mul_r;
  reg [7:0] cnt_r;
  // ----------------------------------------
  // prescaled down counter
  // ----------------------------------------
  always @(posedge clk_sys_i) begin
    done_o <= 1'b0;
    if (!rst_n_i) begin
      pre_r <= 16'h0000;
      mul_r <= 4'h0;
      cnt_r <= 8'h00;
      busy_o <= 1'b0;
    end else if (start_i && !busy_o) begin
      busy_o <= 1'b1;
      cnt_r <= wait_val_i;
      pre_r <= 16'h0000;
      mul_r <= stretch_i ? 4'hb : 4'h0;
    end else if (busy_o) begin
      if (pre_r != STEP_CYC[15:0] - 16'h0001) begin
        pre_r <= pre_r + 16'h0001;
      end else begin
        pre_r <= 16'h0000;
        if (mul_r != 4'h0) begin
          mul_r <= mul_r - 4'h1;
        end else if (cnt_r != 8'h00) begin
          cnt_r <= cnt_r - 8'h01;
          mul_r <= stretch_i ? 4'hb : 4'h0;
        end else begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== prx_pulse_gen.v ====
`timescale 1ns/100ps
`default_nettype none
`include "prx_map.vh"
module prx_pulse_gen #(
  parameter BASE_CYC = `PRX_PULSE_BASE_CYC
) (
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire start_i,
  input wire [1:0] width_i,
  input wire [5:0] count_i,
  output reg led_o,
  output reg busy_o
);
  reg [8:0] wcnt_r;
  reg [6:0] left_r;
  reg [8:0] len_r;
  // ----------------------------------------
  // width decode, 4 8 16 32 us
  // ----------------------------------------
  function [8:0] pw_cyc;
    input [1:0] code;
    begin
      pw_cyc = BASE_CYC[8:0] << code;
    end
  endfunction
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      wcnt_r <= 9'h000;
      left_r <= 7'h00;
      len_r <= 9'h000;
      led_o <= 1'b0;
      busy_o <= 1'b0;
    end else if (start_i && !busy_o) begin
      busy_o <= 1'b1;
      led_o <= 1'b1;
      len_r <= pw_cyc(width_i);
      wcnt_r <= 9'h000;
      left_r <= {1'b0, count_i} + 7'h01;
    end else if (busy_o) begin
      if (wcnt_r != len_r - 9'h001) begin
        wcnt_r <= wcnt_r + 9'h001;
      end else begin
        wcnt_r <= 9'h000;
        if (led_o) begin
          led_o <= 1'b0;
          left_r <= left_r - 7'h01;
        end else if (left_r != 7'h00) begin
          led_o <= 1'b1;
        end else begin
          busy_o <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== prx_cfg_regs.v ====
`timescale 1ns/100ps
`default_nettype none
`include "prx_map.vh"
module prx_cfg_regs #(
  parameter [7:0] REVISION_NUMBER = 8'h01, // arbitrary value
  parameter [5:0] PART_NUMBER = 6'h2a, // arbitrary value
  parameter WAIT_STEP_CYC = `PRX_WAIT_STEP_CYC
) (
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire cycle_start_i,
  input wire prox_int_i,
  input wire prox_int_en_i,
  input wire refl_sat_i,
  input wire amb_sat_i,
  input wire cal_done_i,
  input wire zero_det_i,
  output reg [7:0] rdata_o,
  output reg [1:0] gain_sel_o,
  output reg [3:0] gain_mul_o,
  output reg [4:0] led_code_o,
  output reg [7:0] led_ma_o,
  output reg wait_busy_o,
  output reg wait_done_o,
  output reg led_o,
  output reg pulse_busy_o,
  output reg int_n_o,
  output reg int_oe_o
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [7:0] wait_time_r;
  reg [7:0] wait_config_r;
  reg [7:0] pulse_config_r;
  reg [7:0] gain_drive_config_r;
  reg [7:0] misc_config_r;
  reg [7:0] irq_flags_r;
  reg [7:0] irq_flags_nxt;
  reg [7:0] rdata_nxt;
  wire wait_busy;
  wire wait_done;
  wire led;
  wire pulse_busy;
  wire flags_wr;
  wire flags_rd_clr;
  wire [7:0] set_v;
  wire [7:0] clr_v;
  assign flags_wr = wr_i && (addr_i == `PRX_FLAGS_ADDR);
  assign flags_rd_clr = rd_i && (addr_i == `PRX_FLAGS_ADDR) &&
    misc_config_r[`PRX_CLR_ON_READ_BIT];
  // ----------------------------------------
  // flag events
  // ----------------------------------------
  assign set_v[7] = 1'b0;
  assign set_v[`PRX_F_SAT] = refl_sat_i | amb_sat_i;
  assign set_v[`PRX_F_PROX] = prox_int_i;
  assign set_v[4] = 1'b0;
  assign set_v[`PRX_F_CAL] = cal_done_i;
  assign set_v[`PRX_F_ZERO] = zero_det_i;
  assign set_v[`PRX_F_REFL] = refl_sat_i;
  assign set_v[`PRX_F_AMB] = amb_sat_i;
  // ----------------------------------------
  // clear vector
  // ----------------------------------------
  assign clr_v[7:2] = flags_wr ? wdata_i[7:2] : 6'h00;
  assign clr_v[1] = flags_wr && (wdata_i[1] ||
    wdata_i[`PRX_F_SAT]);
  assign clr_v[0] = flags_wr && (wdata_i[0] ||
    wdata_i[`PRX_F_SAT]);
  always @* begin
    irq_flags_nxt = irq_flags_r;
    if (flags_rd_clr) begin
      irq_flags_nxt = 8'h00;
    end
    irq_flags_nxt = irq_flags_nxt & ~clr_v;
    irq_flags_nxt = (irq_flags_nxt | set_v) & `PRX_FLAG_MASK;
  end
  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always @* begin
    case (addr_i)
      `PRX_WAIT_TIME_ADDR: rdata_nxt = wait_time_r;
      `PRX_WAIT_CFG_ADDR: rdata_nxt = wait_config_r;
      `PRX_PULSE_CFG_ADDR: rdata_nxt = pulse_config_r;
      `PRX_GAIN_CFG_ADDR: rdata_nxt = gain_drive_config_r;
      `PRX_REV_ADDR: rdata_nxt = {5'h00, REVISION_NUMBER[2:0]};
      `PRX_PART_ADDR: rdata_nxt = {PART_NUMBER, 2'b00};
      `PRX_FLAGS_ADDR: rdata_nxt = irq_flags_r;
      `PRX_MISC_CFG_ADDR: rdata_nxt = misc_config_r;
      default: rdata_nxt = 8'h00;
    endcase
  end
  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      wait_time_r <= `PRX_WAIT_TIME_RST;
      wait_config_r <= `PRX_WAIT_CFG_RST;
      pulse_config_r <= `PRX_PULSE_CFG_RST;
      gain_drive_config_r <= `PRX_GAIN_CFG_RST;
      misc_config_r <= `PRX_MISC_CFG_RST;
      irq_flags_r <= 8'h00;
      rdata_o <= 8'h00;
    end else begin
      irq_flags_r <= irq_flags_nxt;
      if (rd_i) begin
        rdata_o <= rdata_nxt;
      end
      if (wr_i) begin
        case (addr_i)
          `PRX_WAIT_TIME_ADDR: wait_time_r <= wdata_i;
          `PRX_WAIT_CFG_ADDR: wait_config_r <= wdata_i;
          `PRX_PULSE_CFG_ADDR: pulse_config_r <= wdata_i;
          `PRX_GAIN_CFG_ADDR: gain_drive_config_r <= wdata_i;
          `PRX_MISC_CFG_ADDR: misc_config_r <= wdata_i;
          default: misc_config_r <= misc_config_r;
        endcase
      end
    end
  end
  // ----------------------------------------
  // analog settings and pin
  // ----------------------------------------
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      gain_sel_o <= 2'h2;
      gain_mul_o <= 4'h4;
      led_code_o <= 5'h00;
      led_ma_o <= 8'h06;
      int_n_o <= 1'b1;
      int_oe_o <= 1'b0;
      wait_busy_o <= 1'b0;
      wait_done_o <= 1'b0;
      led_o <= 1'b0;
      pulse_busy_o <= 1'b0;
    end else begin
      gain_sel_o <= gain_drive_config_r[7:6];
      gain_mul_o <= 4'h1 << gain_drive_config_r[7:6];
      led_code_o <= gain_drive_config_r[4:0];
      led_ma_o <= ({3'h0, gain_drive_config_r[4:0]} + 8'h01) *
        8'd`PRX_LED_STEP_MA;
      int_oe_o <= irq_flags_r[`PRX_F_PROX] && prox_int_en_i;
      int_n_o <= 1'b0;
      wait_busy_o <= wait_busy;
      wait_done_o <= wait_done;
      led_o <= led;
      pulse_busy_o <= pulse_busy;
    end
  end
  // ----------------------------------------
  // timers
  // ----------------------------------------
  prx_wait_timer #(.STEP_CYC(WAIT_STEP_CYC)) u_wait (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .start_i(cycle_start_i),
    .wait_val_i(wait_time_r),
    .stretch_i(wait_config_r[`PRX_WSTRETCH_BIT]),
    .busy_o(wait_busy),
    .done_o(wait_done)
  );
  prx_pulse_gen u_pulse (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .start_i(cycle_start_i),
    .width_i(pulse_config_r[7:6]),
    .count_i(pulse_config_r[5:0]),
    .led_o(led),
    .busy_o(pulse_busy)
  );
endmodule
`default_nettype wire

// ==== prx_cfg_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
module prx_cfg_checker (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic prox_int_i,
  input wire logic prox_int_en_i,
  input wire logic refl_sat_i,
  input wire logic amb_sat_i,
  input wire logic cal_done_i,
  input wire logic zero_det_i,
  input wire logic [7:0] rdata_o,
  input wire logic [3:0] gain_mul_o,
  input wire logic [1:0] gain_sel_o,
  input wire logic [4:0] led_code_o,
  input wire logic [7:0] led_ma_o,
  input wire logic int_oe_o
);
  // ----------------------------------------
  // port relations
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  a_gain_mul_map: assert property (gain_mul_o == 4'(1 << gain_sel_o))
    else $error("gain multiplier wrong");
  a_led_ma_map: assert property (led_ma_o == 8'(6 * (led_code_o + 1)))
    else $error("emitter current wrong");
  a_pin_follows_flag: assert property (prox_int_i && prox_int_en_i ##1
    prox_int_en_i |=> int_oe_o) else $error("pin not driven");
  a_pin_needs_en: assert property (!prox_int_en_i |=> !int_oe_o)
    else $error("pin driven while disabled");
  a_sat_refl_set: assert property (
    refl_sat_i && !wr_i ##1 rd_i && !wr_i && addr_i == 8'h93 |=>
    rdata_o[6] && rdata_o[1]) else $error("refl flag");
  a_sat_amb_set: assert property (
    amb_sat_i && !wr_i ##1 rd_i && !wr_i && addr_i == 8'h93 |=>
    rdata_o[6] && rdata_o[0]) else $error("amb flag");
  a_cal_zero_set: assert property (
    cal_done_i && zero_det_i && !wr_i ##1
    rd_i && !wr_i && addr_i == 8'h93 |=> rdata_o[3:2] == 2'b11)
    else $error("cal or zero flag");
  a_w1c_prox: assert property (wr_i && addr_i == 8'h93 && wdata_i[5] ##0
    !prox_int_i [*3] ##0 rd_i && addr_i == 8'h93 |=> !rdata_o[5])
    else $error("prox flag not cleared");
  a_flag_rsvd_zero: assert property (rd_i && addr_i == 8'h93 |=>
    rdata_o[7] == 1'b0 && rdata_o[4] == 1'b0) else $error("reserved set");
endmodule
bind prx_cfg_regs prx_cfg_checker chk (.clk_sys_i, .rst_n_i, .wr_i, .rd_i,
  .addr_i, .wdata_i, .prox_int_i, .prox_int_en_i, .refl_sat_i, .amb_sat_i,
  .cal_done_i, .zero_det_i, .rdata_o, .gain_mul_o, .gain_sel_o, .led_code_o,
  .led_ma_o, .int_oe_o);
`default_nettype wire

// ==== prx_host_bfm.sv ====
`timescale 1ns/100ps
`default_nettype none
module prx_host_bfm (
  input wire logic clk_sys_i,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o
);
  // ----------------------------------------
  // one byte per strobe, idle gap after
  // ----------------------------------------
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 8'h5a;
    wdata_o = 8'ha5;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    wr_o = w;
    rd_o = !w;
    addr_o = a;
    wdata_o = d;
    @(posedge clk_sys_i);
    #1;
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
    @(posedge clk_sys_i);
    #1;
  endtask
endmodule
`default_nettype wire

// ==== test_proximity_config_status_regs.sv ====
`timescale 1ns/100ps
`default_nettype none
module test_proximity_config_status_regs;
  logic clk_sys_i, rst_n_i, wr_i, rd_i, cycle_start_i, prox_int_en_i;
  logic [7:0] addr_i, wdata_i, rdata_o, led_ma_o;
  logic [4:0] ev, led_code_o;
  logic [1:0] gain_sel_o;
  logic [3:0] gain_mul_o;
  logic wait_busy_o, wait_done_o, led_o, pulse_busy_o, int_n_o, int_oe_o;
  logic [7:0] exp_q[$];
  logic [31:0] seed = 32'h0d706c50;
  logic [31:0] s;
  int err_count = 0, num_checks = 0, c, r, h, d0, k;
  logic [7:0] ra[9] = '{8'h83, 8'h8d, 8'h8e, 8'h8f, 8'h91, 8'h92, 8'h93,
    8'hab, 8'h00};
  logic [7:0] re[9] = '{8'h00, 8'h80, 8'h4f, 8'h80, 8'h01, 8'ha8, 8'h00,
    8'h0c, 8'h00};
  logic [7:0] wt[5] = '{8'h00, 8'h02, 8'h02, 8'h00, 8'hff};
  logic st[5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  prx_cfg_regs #(.WAIT_STEP_CYC(4)) dut (.clk_sys_i, .rst_n_i, .wr_i, .rd_i,
    .addr_i, .wdata_i, .cycle_start_i, .prox_int_i(ev[4]), .prox_int_en_i,
    .refl_sat_i(ev[3]), .amb_sat_i(ev[2]), .cal_done_i(ev[1]),
    .zero_det_i(ev[0]), .rdata_o, .gain_sel_o, .gain_mul_o, .led_code_o,
    .led_ma_o, .wait_busy_o, .wait_done_o, .led_o, .pulse_busy_o, .int_n_o,
    .int_oe_o);
  prx_host_bfm host (.clk_sys_i, .wr_o(wr_i), .rd_o(rd_i), .addr_o(addr_i),
    .wdata_o(wdata_i));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.xfer(1'b0, a, 8'h00);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, d);
  endtask
  task automatic pulse(input logic [4:0] m);
    ev = m;
    @(posedge clk_sys_i);
    #1;
    ev = 5'h00;
  endtask
  task automatic run(output int wd, output int rises, output int hi);
    logic prev;
    prev = 1'b0;
    wd = 0;
    rises = 0;
    hi = 0;
    cycle_start_i = 1'b1;
    for (int n = 1; n < 5300; n++) begin
      @(posedge clk_sys_i);
      #1;
      cycle_start_i = 1'b0;
      if (wait_done_o === 1'b1) wd = n;
      if (led_o === 1'b1 && !prev) rises++;
      if (led_o === 1'b1) hi++;
      if (n == 2) chk({14'h0, wait_busy_o, pulse_busy_o}, 16'h3);
      prev = led_o;
    end
    chk({14'h0, wait_busy_o, pulse_busy_o}, 16'h0);
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // clock, monitor, watchdog, sequence
  // ----------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    if (rd_i === 1'b1) begin
      #2;
      chk({8'h00, rdata_o}, {8'h00, exp_q.pop_front()});
    end
  end
  initial begin
    #5000000;
    err_count++;
    stop_test();
  end
  initial begin
    rst_n_i = 1'b0;
    cycle_start_i = 1'b0;
    prox_int_en_i = 1'b0;
    ev = 5'h00;
    repeat (8) @(posedge clk_sys_i);
    #1;
    chk({15'h0, int_n_o}, 16'h1);
    rst_n_i = 1'b1;
    @(posedge clk_sys_i);
    #1;
    chk({gain_mul_o, 4'h0, led_ma_o}, 16'h4006);
    chk({14'h0, int_n_o, int_oe_o}, 16'h0);
    wr(8'h92, 8'hff);
    wr(8'h91, 8'hff);
    for (int i = 0; i < 9; i++) rd(ra[i], re[i]);
    for (int j = 0; j < 8; j++) begin
      s = rnd();
      if (j == 0) s[4:0] = 5'h1f;
      wr(8'h8f, {s[7:6], 1'b0, s[4:0]});
      chk(16'(gain_mul_o), 16'(1 << s[7:6]));
      chk(16'(led_ma_o), 16'(6 * (s[4:0] + 1)));
      chk({6'h0, gain_sel_o, 3'h0, led_code_o},
        {6'h0, s[7:6], 3'h0, s[4:0]});
    end
    pulse(5'h08);
    rd(8'h93, 8'h42);
    rd(8'h93, 8'h42);
    wr(8'h93, 8'h02);
    rd(8'h93, 8'h40);
    wr(8'h93, 8'h40);
    pulse(5'h04);
    rd(8'h93, 8'h41);
    wr(8'h93, 8'h40);
    rd(8'h93, 8'h00);
    prox_int_en_i = 1'b1;
    pulse(5'h10);
    rd(8'h93, 8'h20);
    chk(16'(int_oe_o), 16'h1);
    wr(8'h93, 8'h00);
    rd(8'h93, 8'h20);
    wr(8'h93, 8'h20);
    rd(8'h93, 8'h00);
    chk(16'(int_oe_o), 16'h0);
    wr(8'hab, 8'h8c);
    pulse(5'h03);
    rd(8'h93, 8'h0c);
    rd(8'h93, 8'h00);
    pulse(5'h03);
    wr(8'h93, 8'h08);
    rd(8'h93, 8'h04);
    for (int i = 0; i < 5; i++) begin
      k = (i == 4) ? 63 : 3 - i;
      wr(8'h83, wt[i]);
      wr(8'h8d, {5'h10, st[i], 2'b00});
      wr(8'h8e, {i[1:0], k[5:0]});
      run(c, r, h);
      if (i == 0) d0 = c;
      chk(16'(c - d0), 16'((wt[i] + 1) * 4 * (st[i] ? 12 : 1) - 4));
      chk(16'(r), 16'(k + 1));
      chk(16'(h), 16'((k + 1) * (40 << i[1:0])));
    end
    stop_test();
  end
endmodule
`default_nettype wire
